/* mlc_exec.sv */
// Execution unit for add to memory, logical products, subroutine call and memory clear.
`timescale 1ns/100ps

module mlc_exec (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           sys_rst,
    // Instruction and addressed memory byte
    input  wire mlc_pkg::mlc_instr_t            instr,
    input  wire logic [mlc_pkg::DATA_W-1:0]     mem_rdata,
    // Core state
    output logic      [mlc_pkg::DATA_W-1:0]     working_register_q,
    output mlc_pkg::mlc_flags_t                 flags_q,
    output logic      [mlc_pkg::PC_W-1:0]       pc_q,
    output logic                                busy_q,
    // Memory write and stack push
    output mlc_pkg::mlc_mem_wr_t                mem_wr_q,
    output mlc_pkg::mlc_push_t                  push_q
);
    // ==================================================
    // Decode.
    typedef enum logic {
        MLC_ST_RUN,
        MLC_ST_CALL_TAIL
    } mlc_state_t;

    mlc_state_t                      state_q;
    mlc_state_t                      state_d;
    logic                            take;
    logic                            is_add;
    logic                            is_and_m;
    logic                            is_and_i;
    logic                            is_and_to_mem;
    logic                            is_call;
    logic                            is_clear;
    logic                            is_load;
    logic [mlc_pkg::DATA_W-1:0]      sum;
    logic [mlc_pkg::DATA_W-1:0]      and_mem;
    logic [mlc_pkg::DATA_W-1:0]      and_imm;
    mlc_pkg::mlc_flags_t             add_flags;
    logic [mlc_pkg::DATA_W-1:0]      working_register_d;
    mlc_pkg::mlc_flags_t             flags_d;
    logic [mlc_pkg::PC_W-1:0]        pc_d;
    mlc_pkg::mlc_mem_wr_t            mem_wr_d;
    mlc_pkg::mlc_push_t              push_d;
    logic [mlc_pkg::PC_W-1:0]        pc_next;
    logic                            mem_write;
    logic [mlc_pkg::DATA_W-1:0]      mem_data;

    function automatic logic op_is(input mlc_pkg::mlc_instr_t i, input mlc_pkg::mlc_op_t op);
        op_is = i.valid && (i.op == op);
    endfunction

    assign take          = (state_q == MLC_ST_RUN) && instr.valid;
    assign is_add        = take && op_is(instr, mlc_pkg::MLC_OP_ADD_TO_MEMORY);
    assign is_and_m      = take && op_is(instr, mlc_pkg::MLC_OP_AND_MEM_TO_ACC);
    assign is_and_i      = take && op_is(instr, mlc_pkg::MLC_OP_AND_IMM_TO_ACC);
    assign is_and_to_mem = take && op_is(instr, mlc_pkg::MLC_OP_LOGIC_PRODUCT_TO_MEMORY);
    assign is_call       = take && op_is(instr, mlc_pkg::MLC_OP_CALL);
    assign is_clear      = take && op_is(instr, mlc_pkg::MLC_OP_ZERO_MEMORY_BYTE);
    assign is_load       = take && op_is(instr, mlc_pkg::MLC_OP_LOAD_WORKING_REGISTER);

    mlc_alu u_alu (
        .working_register (working_register_q),
        .mem_byte         (mem_rdata),
        .imm              (instr.imm),
        .sum              (sum),
        .and_mem          (and_mem),
        .and_imm          (and_imm),
        .add_flags        (add_flags)
    );

    // ==================================================
    // Next state of the working register and flags.
    // The load stands in for the moves of other instruction groups; without it the register never leaves reset.
    assign working_register_d = is_and_m ? and_mem
                              : is_and_i ? and_imm
                              : is_load  ? instr.imm
                              : working_register_q;

    always_comb begin
        flags_d = flags_q;
        if (is_add) begin
            flags_d = add_flags;
        end else if (is_and_m) begin
            flags_d.zero_flag = (and_mem == mlc_pkg::CLEAR_VALUE);
        end else if (is_and_i) begin
            flags_d.zero_flag = (and_imm == mlc_pkg::CLEAR_VALUE);
        end
    end

    // ==================================================
    // Memory write, program counter and stack push.
    assign mem_write = is_add || is_and_to_mem || is_clear;
    assign mem_data  = is_add        ? sum
                     : is_and_to_mem ? and_mem
                     : mlc_pkg::CLEAR_VALUE;

    assign mem_wr_d.en   = mem_write;
    assign mem_wr_d.addr = instr.addr;
    assign mem_wr_d.data = mem_data;

    assign pc_next     = pc_q + mlc_pkg::PC_STEP;
    assign push_d.en   = is_call;
    assign push_d.data = pc_next;
    assign pc_d        = is_call ? instr.target
                       : take    ? pc_next
                       : pc_q;

    // ==================================================
    // Call sequencing.
    always_comb begin
        unique case (state_q)
            MLC_ST_RUN:       state_d = is_call ? MLC_ST_CALL_TAIL : MLC_ST_RUN;
            MLC_ST_CALL_TAIL: state_d = MLC_ST_RUN;
        endcase
    end

    // ==================================================
    // Registers.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= MLC_ST_RUN;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q  <= (state_d == MLC_ST_CALL_TAIL);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            working_register_q <= mlc_pkg::WREG_RST;
            flags_q            <= mlc_pkg::FLAGS_RST;
        end else begin
            working_register_q <= working_register_d;
            flags_q            <= flags_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_q <= mlc_pkg::PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_wr_q <= '0;
            push_q   <= '0;
        end else begin
            mem_wr_q <= mem_wr_d;
            push_q   <= push_d;
        end
    end
endmodule // mlc_exec

/* mlc_alu.sv */
// Package of shared constants and types, and the combinational arithmetic unit.
`timescale 1ns/100ps

// ==================================================
// Shared constants and types.
package mlc_pkg;
    localparam int          DATA_W      = 8;
    localparam int          PC_W        = 12;
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  WREG_RST    = 8'h00;
    localparam logic [7:0]  CLEAR_VALUE = 8'h00;
    localparam logic [11:0] PC_RST      = 12'h000;
    localparam logic [11:0] PC_STEP     = 12'h001;
    localparam int          NIBBLE_MSB  = 3;
    localparam int          SIGN_BIT    = 7;

    typedef enum logic [2:0] {
        MLC_OP_NOP,
        MLC_OP_ADD_TO_MEMORY,
        MLC_OP_AND_MEM_TO_ACC,
        MLC_OP_AND_IMM_TO_ACC,
        MLC_OP_LOGIC_PRODUCT_TO_MEMORY,
        MLC_OP_CALL,
        MLC_OP_ZERO_MEMORY_BYTE,
        MLC_OP_LOAD_WORKING_REGISTER
    } mlc_op_t;

    typedef struct packed {
        logic              valid;
        mlc_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] imm;
        logic [PC_W-1:0]   target;
    } mlc_instr_t;

    typedef struct packed {
        logic twos_complement_wrap_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
        logic sign_guard_flag;
    } mlc_flags_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mlc_mem_wr_t;

    typedef struct packed {
        logic            en;
        logic [PC_W-1:0] data;
    } mlc_push_t;

    localparam mlc_flags_t FLAGS_RST = '0;
endpackage

// ==================================================
// Adder with full flag set, and both logical products.
module mlc_alu (
    // Operands
    input  wire logic [mlc_pkg::DATA_W-1:0] working_register,
    input  wire logic [mlc_pkg::DATA_W-1:0] mem_byte,
    input  wire logic [mlc_pkg::DATA_W-1:0] imm,
    // Results
    output logic      [mlc_pkg::DATA_W-1:0] sum,
    output logic      [mlc_pkg::DATA_W-1:0] and_mem,
    output logic      [mlc_pkg::DATA_W-1:0] and_imm,
    output mlc_pkg::mlc_flags_t             add_flags
);
    logic [mlc_pkg::DATA_W:0] wide_sum;
    logic [4:0]               low_sum;
    logic                     wrap;

    assign wide_sum = {1'b0, working_register} + {1'b0, mem_byte};
    assign low_sum  = {1'b0, working_register[mlc_pkg::NIBBLE_MSB:0]} + {1'b0, mem_byte[mlc_pkg::NIBBLE_MSB:0]};
    assign sum      = wide_sum[mlc_pkg::DATA_W-1:0];
    assign wrap     = (working_register[mlc_pkg::SIGN_BIT] == mem_byte[mlc_pkg::SIGN_BIT])
                    && (sum[mlc_pkg::SIGN_BIT] != working_register[mlc_pkg::SIGN_BIT]);
    assign and_mem  = working_register & mem_byte;
    assign and_imm  = working_register & imm;

    // The sign guard flag is the true sign of the sum, corrected for wrap.
    assign add_flags.twos_complement_wrap_flag = wrap;
    assign add_flags.zero_flag                 = (sum == mlc_pkg::CLEAR_VALUE);
    assign add_flags.nibble_carry_flag         = low_sum[4];
    assign add_flags.carry_flag                = wide_sum[mlc_pkg::DATA_W];
    assign add_flags.sign_guard_flag           = wrap ^ sum[mlc_pkg::SIGN_BIT];
endmodule // mlc_alu

/* mlc_exec_chk.sv */
// Checker for the execution unit ports.
`timescale 1ns/100ps
module mlc_exec_chk (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 sys_rst,
    // Watched ports
    input wire mlc_pkg::mlc_instr_t  instr,
    input wire logic [7:0]           mem_rdata,
    input wire logic [7:0]           working_register_q,
    input wire mlc_pkg::mlc_flags_t  flags_q,
    input wire logic [11:0]          pc_q,
    input wire logic                 busy_q,
    input wire mlc_pkg::mlc_mem_wr_t mem_wr_q,
    input wire mlc_pkg::mlc_push_t   push_q
);
    // ==================================================
    // Operation taken at this edge, zero when none.
    wire logic [2:0] op_tk = (instr.valid && !busy_q) ? instr.op : 3'h0;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_add_sum_flags: assert property (op_tk == 3'h1 |=> mem_wr_q.en && mem_wr_q.addr == $past(instr.addr)
        && mem_wr_q.data == 8'($past(working_register_q) + $past(mem_rdata)) && flags_q.zero_flag == !mem_wr_q.data)
        else $error("add to memory wrong");
    a_and_mem_acc: assert property (op_tk == 3'h2 |=> !mem_wr_q.en
        && working_register_q == ($past(working_register_q) & $past(mem_rdata)) && $stable(flags_q.carry_flag)
        && flags_q.zero_flag == !working_register_q)
        else $error("memory product wrong");
    a_and_imm_acc: assert property (op_tk == 3'h3 |=> flags_q.zero_flag == !working_register_q
        && working_register_q == ($past(working_register_q) & $past(instr.imm)) && $stable(flags_q.sign_guard_flag))
        else $error("immediate product wrong");
    a_and_to_mem: assert property (op_tk == 3'h4 |=> mem_wr_q.en && $stable(working_register_q)
        && mem_wr_q.data == ($past(working_register_q) & $past(mem_rdata)) && mem_wr_q.addr == $past(instr.addr))
        else $error("product to memory wrong");
    a_call_push: assert property (op_tk == 3'h5 |=> push_q.en && push_q.data == $past(pc_q) + 12'h001
        && pc_q == $past(instr.target) && $stable(flags_q))
        else $error("call push wrong");
    a_call_two_cycle: assert property (op_tk == 3'h5 |=> busy_q ##1 !busy_q && !push_q.en)
        else $error("call cycle count wrong");
    a_clear_byte: assert property (op_tk == 3'h6 |=> mem_wr_q.en && mem_wr_q.data == 8'h00 && $stable(flags_q)
        && mem_wr_q.addr == $past(instr.addr))
        else $error("clear wrong");
    a_pc_one_step: assert property (op_tk != 3'h5 && instr.valid && !busy_q |=> pc_q == $past(pc_q) + 12'h001)
        else $error("pc step wrong");
endmodule // mlc_exec_chk

/* tb_mlc_exec.sv */
// Testbench for the execution unit.
`timescale 1ns/100ps
module tb_mlc_exec;
    logic                 ref_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    mlc_pkg::mlc_instr_t  instr = '0;
    logic [7:0]           mem_rdata = 8'h00;
    logic [7:0]           working_register_q;
    mlc_pkg::mlc_flags_t  flags_q;
    logic [11:0]          pc_q;
    logic                 busy_q;
    mlc_pkg::mlc_mem_wr_t mem_wr_q;
    mlc_pkg::mlc_push_t   push_q;
    logic [7:0]           exp_wr = 8'h00;
    mlc_pkg::mlc_flags_t  exp_fl = '0;
    logic [11:0]          exp_pc = 12'h000;
    int                   num_errors = 0;
    int                   compares = 0;
    int                   cycles = 0;
    // ==================================================
    // Clock, timeout and device.
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 500) begin
            num_errors++;
            wrap_up();
        end
    end
    mlc_exec i_mlc_exec (.ref_clk, .sys_rst, .instr, .mem_rdata, .working_register_q, .flags_q, .pc_q, .busy_q,
        .mem_wr_q, .push_q);
    // ==================================================
    // Shared tasks.
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic mlc_pkg::mlc_flags_t addf(input logic [7:0] a, input logic [7:0] m);
        logic [8:0] s;
        logic       v;
        s = a + m;
        v = (a[7] == m[7]) && (s[7] != a[7]);
        addf = '{v, s[7:0] == 8'h00, (a[3:0] + m[3:0]) > 5'h0F, s[8], v ^ s[7]};
    endfunction
    task automatic run(input logic [2:0] op, input logic [7:0] a, x, m, input logic [11:0] t, input logic wr,
        input logic [7:0] wd);
        logic [11:0] nx;
        nx = exp_pc + 12'h001;
        instr <= '{1'b1, mlc_pkg::mlc_op_t'(op), a, x, t};
        mem_rdata <= m;
        @(posedge ref_clk);
        instr.valid <= (op == 3'h5);
        @(negedge ref_clk);
        exp_pc = (op == 3'h5) ? t : nx;
        cmp(working_register_q, exp_wr, "working register");
        cmp(flags_q, exp_fl, "flags");
        cmp(pc_q, exp_pc, "program counter");
        cmp(busy_q, op == 3'h5, "busy");
        cmp(push_q.en, op == 3'h5, "push strobe");
        cmp(mem_wr_q.en, wr, "write strobe");
        if (op == 3'h5) cmp(push_q.data, nx, "pushed address");
        if (wr) cmp({mem_wr_q.addr, mem_wr_q.data}, {a, wd}, "memory write");
        @(posedge ref_clk);
        if (op == 3'h5) instr.valid <= 1'b0;
    endtask
    task automatic load_wr(input logic [7:0] x);
        exp_wr = x;
        run(3'h7, 8'h00, x, 8'h00, 12'h000, 1'b0, 8'h00);
    endtask
    // ==================================================
    // Scenarios.
    task automatic sc_add();
        exp_fl = addf(exp_wr, 8'h00);
        run(3'h1, 8'h12, 8'h00, 8'h00, 12'h000, 1'b1, 8'h00);
        load_wr(8'h8F);
        exp_fl = addf(exp_wr, 8'h81);
        run(3'h1, 8'h13, 8'h00, 8'h81, 12'h000, 1'b1, 8'h10);
        exp_fl = addf(exp_wr, 8'h71);
        run(3'h1, 8'h14, 8'h00, 8'h71, 12'h000, 1'b1, 8'h00);
    endtask
    task automatic sc_and();
        exp_wr = 8'h80;
        exp_fl.zero_flag = 1'b0;
        run(3'h2, 8'h20, 8'h00, 8'hF0, 12'h000, 1'b0, 8'h00);
        exp_wr = 8'h00;
        exp_fl.zero_flag = 1'b1;
        run(3'h3, 8'h20, 8'h7F, 8'hFF, 12'h000, 1'b0, 8'h00);
        load_wr(8'h3C);
        run(3'h4, 8'h21, 8'h00, 8'hA5, 12'h000, 1'b1, 8'h24);
    endtask
    task automatic sc_clear();
        run(3'h6, 8'hFF, 8'h00, 8'h3C, 12'h000, 1'b1, 8'h00);
    endtask
    task automatic sc_call();
        run(3'h5, 8'h00, 8'h00, 8'h00, 12'h7FF, 1'b0, 8'h00);
        @(negedge ref_clk);
        cmp({busy_q, push_q.en, pc_q}, {2'b00, exp_pc}, "call second cycle");
        @(posedge ref_clk);
    endtask
    task automatic sc_reset();
        sys_rst <= 1'b1;
        @(negedge ref_clk);
        exp_wr = 8'h00;
        exp_fl = '0;
        exp_pc = 12'h000;
        cmp(working_register_q, exp_wr, "reset working register");
        cmp(flags_q, exp_fl, "reset flags");
        cmp(pc_q, exp_pc, "reset program counter");
        cmp({busy_q, push_q.en, mem_wr_q.en}, 3'h0, "reset strobes");
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        load_wr(8'h5A);
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        sc_add();
        sc_and();
        sc_clear();
        sc_call();
        sc_reset();
        wrap_up();
    end
endmodule // tb_mlc_exec
bind mlc_exec mlc_exec_chk i_mlc_exec_chk (.ref_clk, .sys_rst, .instr, .mem_rdata, .working_register_q, .flags_q,
    .pc_q, .busy_q, .mem_wr_q, .push_q);
